// ===== hw/lbm_monitor.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module lbm_monitor
  import lbm_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = LBM_CYCLE_TICKS
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Monitored reference, asynchronous
  input wire lbm_ref_type i_ref,
  // Bucket state
  output logic [LBM_LEVEL_W-1:0] o_level,
  output logic o_alarm
);

  // Bus slave state
  lbm_cfg_type cfg;
  lbm_cfg_type next_cfg;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic addr_ok;

  // Monitor state
  lbm_ref_type ref_meta;
  lbm_ref_type ref_sync;
  logic seen_fault;
  logic next_seen_fault;
  logic [LBM_LEVEL_W-1:0] next_level;
  logic [LBM_CLEAN_W-1:0] clean_cnt;
  logic [LBM_CLEAN_W-1:0] next_clean_cnt;
  logic next_alarm;
  logic cycle_end;
  logic faulty;
  logic [LBM_RUN_W-1:0] run_len;
  logic run_done;

  lbm_cycle_timer #(
    .TICKS(CYCLE_TICKS)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .o_tick(cycle_end)
  );

  // Address phase taken only for word transfers; others complete with no effect
  assign addr_ok = i_hsel && (i_htrans == LBM_HTRANS_NONSEQ || i_htrans[1])
                   && i_hready && (i_hsize == LBM_HSIZE_WORD);

  always_comb begin
    next_wr_pend = addr_ok && i_hwrite;
    next_wr_idx = i_haddr[LBM_IDX_LSB +: LBM_IDX_W];
    next_cfg = cfg;
    if (wr_pend) begin
      unique case (wr_idx)
        LBM_IDX_UPPER: next_cfg.upper = i_hwdata[LBM_LEVEL_W-1:0];
        LBM_IDX_CAPACITY: next_cfg.capacity = i_hwdata[LBM_LEVEL_W-1:0];
        LBM_IDX_LOWER: next_cfg.lower = i_hwdata[LBM_LEVEL_W-1:0];
        LBM_IDX_DECAY: next_cfg.decay = i_hwdata[LBM_DECAY_W-1:0];
        default: next_cfg = cfg;
      endcase
    end
    // Read from next_cfg so a read right after a write sees the new value
    next_hrdata = o_hrdata;
    if (addr_ok && !i_hwrite) begin
      next_hrdata = '0;
      if (lbm_hit(i_haddr, LBM_IDX_UPPER)) begin
        next_hrdata[LBM_LEVEL_W-1:0] = next_cfg.upper;
      end else if (lbm_hit(i_haddr, LBM_IDX_CAPACITY)) begin
        next_hrdata[LBM_LEVEL_W-1:0] = next_cfg.capacity;
      end else if (lbm_hit(i_haddr, LBM_IDX_LOWER)) begin
        next_hrdata[LBM_LEVEL_W-1:0] = next_cfg.lower;
      end else if (lbm_hit(i_haddr, LBM_IDX_DECAY)) begin
        next_hrdata[LBM_DECAY_W-1:0] = next_cfg.decay;
      end else if (lbm_hit(i_haddr, LBM_IDX_STATUS)) begin
        next_hrdata[LBM_LEVEL_W-1:0] = o_level;
        next_hrdata[LBM_STAT_ALARM_BIT] = o_alarm;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cfg <= '{decay: LBM_RST_DECAY, capacity: LBM_RST_CAPACITY,
               upper: LBM_RST_UPPER, lower: LBM_RST_LOWER};
      wr_pend <= 1'b0;
      wr_idx <= '0;
      o_hrdata <= '0;
      o_hreadyout <= 1'b0;
      o_hresp <= LBM_HRESP_OKAY;
    end else begin
      cfg <= next_cfg;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= LBM_HRESP_OKAY;
    end
  end

  // Two-flop synchroniser for the asynchronous reference status
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ref_meta <= '0;
      ref_sync <= '0;
    end else begin
      ref_meta <= i_ref;
      ref_sync <= ref_meta;
    end
  end

  assign faulty = seen_fault || ref_sync.fail || ref_sync.erratic;
  assign run_len = lbm_run_len(cfg.decay);
  assign run_done = ({1'b0, clean_cnt} == run_len - LBM_RUN_W'(1));

  always_comb begin
    next_seen_fault = seen_fault || ref_sync.fail || ref_sync.erratic;
    next_level = o_level;
    next_clean_cnt = clean_cnt;
    if (cycle_end) begin
      next_seen_fault = 1'b0;
      if (faulty) begin
        next_clean_cnt = '0;
        // Capacity may be lowered below the level; then it only waits to leak
        if (o_level < cfg.capacity) begin
          next_level = o_level + LBM_LEVEL_W'(1);
        end
      end else if (run_done) begin
        next_clean_cnt = '0;
        if (o_level != '0) begin
          next_level = o_level - LBM_LEVEL_W'(1);
        end
      end else begin
        next_clean_cnt = clean_cnt + LBM_CLEAN_W'(1);
      end
    end
    // Hysteresis between the two thresholds keeps the alarm from chattering
    next_alarm = o_alarm;
    if (o_level >= cfg.upper) begin
      next_alarm = 1'b1;
    end else if (o_level <= cfg.lower) begin
      next_alarm = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      seen_fault <= 1'b0;
      o_level <= '0;
      clean_cnt <= '0;
      o_alarm <= 1'b0;
    end else begin
      seen_fault <= next_seen_fault;
      o_level <= next_level;
      clean_cnt <= next_clean_cnt;
      o_alarm <= next_alarm;
    end
  end

  property p_fault_held;
    @(posedge i_ref_clk) disable iff (i_srst)
    (ref_sync.fail && !cycle_end) |=> (seen_fault || cycle_end) [*1] ##0 faulty;
  endproperty
  a_fault_held: assert property (p_fault_held) else $error("fault not held for the cycle");

  property p_fill;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && faulty && o_level < cfg.capacity) |=> (o_level == $past(o_level) + 8'h01);
  endproperty
  a_fill: assert property (p_fill) else $error("faulty cycle did not add one");

  property p_leak;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && !faulty && run_done && o_level != 8'h00)
      |=> (o_level == $past(o_level) - 8'h01) && (clean_cnt == 3'h0);
  endproperty
  a_leak: assert property (p_leak) else $error("clean run did not leak one");

  property p_decode;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cfg.decay == 2'h3 |-> run_len == 4'h8) and (cfg.decay == 2'h0 |-> run_len == 4'h1)
      and (cfg.decay == 2'h2 |-> run_len == 4'h4)
      and (cfg.decay == 2'h1 |-> run_len == 4'h2);
  endproperty
  a_decode: assert property (p_decode) else $error("decay code decoded wrongly");

  property p_hold_level;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && !faulty && !run_done) |=> $stable(o_level) && (clean_cnt == $past(clean_cnt) + 3'h1);
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("leak before clean run complete");

  property p_saturate;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && faulty && o_level >= cfg.capacity) |=> $stable(o_level);
  endproperty
  a_saturate: assert property (p_saturate) else $error("bucket filled past capacity");

  property p_alarm_set;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_level >= cfg.upper) |=> o_alarm;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not raised at upper threshold");

  property p_alarm_clr;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_level <= cfg.lower && o_level < cfg.upper) |=> !o_alarm;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not cleared at lower threshold");

  // Writes land at the edge that ends the data phase
  property p_decay_write;
    @(posedge i_ref_clk) disable iff (i_srst)
    (wr_pend && wr_idx == LBM_IDX_DECAY) |=> cfg.decay == LBM_DECAY_W'($past(i_hwdata));
  endproperty
  a_decay_write: assert property (p_decay_write) else $error("decay write lost");

  property p_capacity_write;
    @(posedge i_ref_clk) disable iff (i_srst)
    (wr_pend && wr_idx == LBM_IDX_CAPACITY) |=> cfg.capacity == LBM_LEVEL_W'($past(i_hwdata));
  endproperty
  a_capacity_write: assert property (p_capacity_write) else $error("capacity write lost");

  property p_upper_write;
    @(posedge i_ref_clk) disable iff (i_srst)
    (wr_pend && wr_idx == LBM_IDX_UPPER) |=> cfg.upper == LBM_LEVEL_W'($past(i_hwdata));
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("upper threshold write lost");

  property p_lower_write;
    @(posedge i_ref_clk) disable iff (i_srst)
    (wr_pend && wr_idx == LBM_IDX_LOWER) |=> cfg.lower == LBM_LEVEL_W'($past(i_hwdata));
  endproperty
  a_lower_write: assert property (p_lower_write) else $error("lower threshold write lost");

  // Unused decay bits must never leak onto the bus
  property p_decay_read;
    @(posedge i_ref_clk) disable iff (i_srst)
    (addr_ok && !i_hwrite && lbm_hit(i_haddr, LBM_IDX_DECAY))
      |=> (o_hrdata >> LBM_DECAY_W) == 32'h0;
  endproperty
  a_decay_read: assert property (p_decay_read) else $error("decay upper bits not zero");

  property p_status_read;
    @(posedge i_ref_clk) disable iff (i_srst)
    (addr_ok && !i_hwrite && lbm_hit(i_haddr, LBM_IDX_STATUS))
      |=> o_hrdata[LBM_STAT_ALARM_BIT] == $past(o_alarm) && o_hrdata[LBM_LEVEL_W-1:0] == $past(o_level);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_step;
    @(posedge i_ref_clk) disable iff (i_srst)
    $changed(o_level)
      |-> (o_level == $past(o_level) + 8'h01) || (o_level == $past(o_level) - 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("level moved by more than one");

  property p_level_quiet;
    @(posedge i_ref_clk) disable iff (i_srst)
    !cycle_end |=> $stable(o_level);
  endproperty
  a_level_quiet: assert property (p_level_quiet) else $error("level moved inside a cycle");

  property p_floor;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && !faulty && o_level == 8'h00) |=> o_level == 8'h00;
  endproperty
  a_floor: assert property (p_floor) else $error("leak below empty");

  property p_run_restart;
    @(posedge i_ref_clk) disable iff (i_srst)
    (cycle_end && faulty) |=> clean_cnt == 3'h0;
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("clean run not restarted");

  property p_alarm_between;
    @(posedge i_ref_clk) disable iff (i_srst)
    (o_level < cfg.upper && o_level > cfg.lower) |=> o_alarm == $past(o_alarm);
  endproperty
  a_alarm_between: assert property (p_alarm_between) else $error("alarm chattered");

  property p_alarm_rise;
    @(posedge i_ref_clk) disable iff (i_srst)
    $rose(o_alarm)
      |-> $past(o_level) >= $past(cfg.upper);
  endproperty
  a_alarm_rise: assert property (p_alarm_rise) else $error("alarm rose below upper threshold");

  property p_alarm_fall;
    @(posedge i_ref_clk) disable iff (i_srst)
    $fell(o_alarm)
      |-> $past(o_level) <= $past(cfg.lower);
  endproperty
  a_alarm_fall: assert property (p_alarm_fall) else $error("alarm fell above lower threshold");

endmodule : lbm_monitor

// ===== hw/lbm_pkg.sv
package lbm_pkg;

  // Clock and monitoring cycle
  localparam int unsigned LBM_CLK_HZ = 40_000_000;
  localparam int unsigned LBM_CYCLE_MS = 128;
  localparam int unsigned LBM_MS_PER_S = 1000;
  localparam int unsigned LBM_CYCLE_TICKS = LBM_CLK_HZ / LBM_MS_PER_S * LBM_CYCLE_MS;

  // Register indices; byte address is four times the index
  localparam int unsigned LBM_IDX_LSB = 2;
  localparam int unsigned LBM_IDX_W = 8;
  localparam logic [7:0] LBM_IDX_UPPER = 8'h5C;
  localparam logic [7:0] LBM_IDX_CAPACITY = 8'h5D;
  localparam logic [7:0] LBM_IDX_LOWER = 8'h5E;
  localparam logic [7:0] LBM_IDX_DECAY = 8'h5F;
  localparam logic [7:0] LBM_IDX_STATUS = 8'h60;

  // Reset values
  localparam logic [1:0] LBM_RST_DECAY = 2'h1;
  localparam logic [7:0] LBM_RST_CAPACITY = 8'h08;
  localparam logic [7:0] LBM_RST_UPPER = 8'h06;
  localparam logic [7:0] LBM_RST_LOWER = 8'h04;

  // Field layout
  localparam int unsigned LBM_DECAY_W = 2;
  localparam int unsigned LBM_LEVEL_W = 8;
  localparam int unsigned LBM_RUN_W = 4;
  localparam int unsigned LBM_CLEAN_W = 3;
  localparam int unsigned LBM_STAT_ALARM_BIT = 8;

  // AHB-Lite encodings
  localparam logic [1:0] LBM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] LBM_HSIZE_WORD = 3'h2;
  localparam logic LBM_HRESP_OKAY = 1'h0;

  typedef struct packed {
    logic [LBM_DECAY_W-1:0] decay;
    logic [LBM_LEVEL_W-1:0] capacity;
    logic [LBM_LEVEL_W-1:0] upper;
    logic [LBM_LEVEL_W-1:0] lower;
  } lbm_cfg_type;

  typedef struct packed {
    logic fail;
    logic erratic;
  } lbm_ref_type;

  // Clean cycles per leak: 1, 2, 4 or 8
  function automatic logic [LBM_RUN_W-1:0] lbm_run_len(input logic [LBM_DECAY_W-1:0] decay);
    lbm_run_len = LBM_RUN_W'(1) << decay;
  endfunction : lbm_run_len

  function automatic logic lbm_hit(input logic [31:0] addr, input logic [7:0] idx);
    lbm_hit = (addr[LBM_IDX_LSB +: LBM_IDX_W] == idx);
  endfunction : lbm_hit

endpackage : lbm_pkg

// ===== hw/lbm_cycle_timer.sv
`timescale 1ns/1ps
module lbm_cycle_timer #(
  parameter int unsigned TICKS = 5_120_000
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Cycle end pulse
  output logic o_tick
);

  localparam int unsigned CW = (TICKS > 2) ? $clog2(TICKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = (cnt == LAST) ? '0 : cnt + ONE;
    next_tick = (cnt == LAST);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end

  // One pulse per monitoring cycle
  property p_tick_single;
    @(posedge i_ref_clk) disable iff (i_srst)
    o_tick |=> !o_tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("cycle tick longer than one clock");

endmodule : lbm_cycle_timer

// ===== bench/leaky_bucket_activity_monitor_tb_top.sv
`timescale 1ns/1ps
module leaky_bucket_activity_monitor_tb_top
  import lbm_pkg::*;
;
  // Short cycle keeps the run small
  localparam int CT = 16;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = LBM_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  lbm_ref_type ref_in = '0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic [7:0] level;
  wire logic alarm;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic [7:0] prev;

  lbm_monitor #(.CYCLE_TICKS(CT)) dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_ref(ref_in), .o_level(level), .o_alarm(alarm)
  );

  always #12.5 i_ref_clk = ~i_ref_clk;

  task stop_test;
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // Hang guard, about twelve times the expected run of roughly a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge i_ref_clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= LBM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge i_ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, LBM_HRESP_OKAY});
  endtask : ahb

  task rchk(input logic [7:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Edges until the level moves, bounded
  task wait_chg(output int cnt);
    prev = level;
    cnt = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      cnt++;
    end while (level === prev && cnt < 400);
  endtask : wait_chg

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rchk(LBM_IDX_DECAY, 32'h01);
    rchk(LBM_IDX_CAPACITY, 32'h08);
    rchk(LBM_IDX_STATUS, 32'h0);
    rchk(8'h10, 32'h0);
    // Byte-sized write must leave the register alone
    hsize <= 3'h0;
    ahb(1'b1, LBM_IDX_CAPACITY, 32'h33);
    hsize <= LBM_HSIZE_WORD;
    rchk(LBM_IDX_CAPACITY, 32'h08);
    ahb(1'b1, LBM_IDX_DECAY, 32'hFF);
    rchk(LBM_IDX_DECAY, 32'h03);
    ahb(1'b1, LBM_IDX_CAPACITY, 32'h05);
    ahb(1'b1, LBM_IDX_UPPER, 32'h04);
    ahb(1'b1, LBM_IDX_LOWER, 32'h02);
    ahb(1'b1, LBM_IDX_DECAY, 32'h00);
    rchk(LBM_IDX_CAPACITY, 32'h05);
    // Fill: one count per faulty cycle, alarm at the upper mark
    @(posedge i_ref_clk);
    ref_in <= '{fail: 1'b1, erratic: 1'b0};
    for (int i = 0; i < 5; i++) begin
      wait_chg(n);
      chk(level, prev + 8'h1);
      // One edge of each cycle went to the alarm check
      if (i > 0) chk(n + 1, CT);
      @(posedge i_ref_clk);
      #1;
      chk(alarm, level >= 8'h4);
    end
    // Further faults must not pass the capacity
    repeat (3 * CT) @(posedge i_ref_clk);
    #1;
    chk(level, 8'h05);
    rchk(LBM_IDX_STATUS, (32'h1 << LBM_STAT_ALARM_BIT) | 32'h05);
    // Leak at the fill rate; alarm holds until the lower mark
    ref_in <= '0;
    for (int i = 0; i < 5; i++) begin
      wait_chg(n);
      chk(level, prev - 8'h1);
      if (i > 0) chk(n + 1, CT);
      @(posedge i_ref_clk);
      #1;
      chk(alarm, level > 8'h2);
    end
    // Slower leak codes, erratic input used on odd codes
    for (int d = 1; d < 4; d++) begin
      ahb(1'b1, LBM_IDX_DECAY, d);
      @(posedge i_ref_clk);
      ref_in <= '{fail: d[0] == 1'b0, erratic: d[0]};
      wait_chg(n);
      chk(level, 8'h1);
      wait_chg(n);
      @(posedge i_ref_clk);
      ref_in <= '0;
      // Last step down spans exactly one full clean run
      for (int k = 0; k < 6 && level !== 8'h0; k++) wait_chg(n);
      chk(level, 8'h0);
      chk(n, CT << d);
    end
    // Mid-run reset brings the configuration back
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rchk(LBM_IDX_DECAY, 32'h01);
    rchk(LBM_IDX_UPPER, 32'h06);
    stop_test();
  end
endmodule : leaky_bucket_activity_monitor_tb_top
